// >>> pkg/timer_defs.svh
// constants for the dual 8-bit cascadable timer
// Overview of operation
// [R1] two separate 8-bit channels, or both joined as one 16-bit counter
// [R2] each channel raises its interrupt request when count equals its compare value; joined, the code raises only channel 2's, on the 16-bit match
// [R3] software writes compare registers with byte accesses only, never word
// [R4] compare spans 00H-FFH per channel, 0000H-FFFFH when joined
// [R5] compare registers hold undefined contents after reset
// [R6] software writes joined compare data only while counting is stopped
// [R7] compare lowered below count: counter wraps past maximum before matching
// [R8] software restarts the timer after lowering a compare value
// [R9] reset clears both 8-bit count registers to 00H
// [R10] byte reads of counts when separate, one word read of joined count
// [R11] clock choices: input falling or rising edge, main clock /2../1024, /4096
// [R12] clock select written by byte access, resets to 00H (falling edge)
// [R13] software stops counting before changing the clock select value
// [R14] event counter mode counts pulses on the channel's external input
// [R15] each channel can drive a square wave on its own output pin
// [R16] two count registers, two compare registers, two wave outputs
// [R17] clock select bits 3:0 pick channel 1 clock, bits 7:4 channel 2
// [R18] on match the counter clears to 0 and keeps counting
// [R19] with output enable set, output pin inverts at each match
// [R20] joined bit makes channel 1 overflow clock channel 2; channel 1 enable runs it
// [R21] codes 0 fall, 1 rise, 5-14 divide 2-1024, 15 divide 4096
// [R22] joined: channel 2 registers are upper byte, channel 1 lower byte
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define ADDR_CLOCK_SELECT  16'hFF41
`define ADDR_MODE_CONTROL  16'hFF49
`define ADDR_OUTPUT_CTRL   16'hFF4A
`define ADDR_COUNT_CH1     16'hFF50
`define ADDR_COUNT_CH2     16'hFF51
`define ADDR_COMPARE_CH1   16'hFF52
`define ADDR_COMPARE_CH2   16'hFF53

`define RST_CLOCK_SELECT   8'h00
`define RST_MODE_CONTROL   8'h00
`define RST_OUTPUT_CTRL    8'h00
`define RST_COUNT          8'h00

`define BIT_ENABLE_CH1     0
`define BIT_ENABLE_CH2     1
`define BIT_JOINED         2
`define BIT_OUT_EN_CH1     0
`define BIT_OUT_EN_CH2     4
`define CSEL_W             4

`define CSEL_FALL          4'h0
`define CSEL_RISE          4'h1
`define CSEL_DIV_FIRST     4'h5
`define CSEL_DIV_LAST      4'hE
`define CSEL_DIV4096       4'hF
`define DIV_SHIFT_OFFSET   4'h4
`define DIV4096_SHIFT      4'hC
`define PRESCALE_BITS      12
`define COUNT_MAX          8'hFF

`endif

// >>> pkg/timer_pkg.sv
// types shared by the timer modules
package timer_pkg;
  typedef logic [3:0]  clk_code_t;
  typedef logic [7:0]  count_t;
  typedef enum logic [1:0] {SRC_FALL, SRC_RISE, SRC_DIV, SRC_NONE} tick_src_t;
endpackage : timer_pkg

// >>> pkg/tick_if.sv
// count clock request and answer between top and tick selector
`timescale 1ns/1ns
interface tick_if #(parameter int PRESCALE_W = 12);
  logic [3:0]            sel;
  logic                  ev_rise;
  logic                  ev_fall;
  logic [PRESCALE_W-1:0] prescale;
  logic                  tick;
  modport gen  (input sel, input ev_rise, input ev_fall, input prescale, output tick);
  modport user (output sel, output ev_rise, output ev_fall, output prescale, input tick);
endinterface : tick_if

// >>> hw/timer_tick_sel.sv
// count clock selector for one channel
`timescale 1ns/1ns
`include "timer_defs.svh"
module timer_tick_sel
  import timer_pkg::*;
#(
  parameter int PRESCALE_W = 12
) (
  input  wire logic clk_sys_i, // system clock
  input  wire logic rstn_i,    // synchronised reset, active low
  tick_if.gen       t          // selection in, tick out
);
  tick_src_t             src;
  logic [3:0]            shift;
  logic [PRESCALE_W-1:0] mask;
  logic                  tick_reg;

  initial begin
    if (PRESCALE_W < `PRESCALE_BITS) $error("prescaler too narrow for divide by 4096");
  end

  always_comb begin
    src   = SRC_NONE;
    shift = 4'h0;
    if (t.sel == `CSEL_FALL) begin // [R21]
      src = SRC_FALL;
    end else if (t.sel == `CSEL_RISE) begin
      src = SRC_RISE;
    end else if (t.sel >= `CSEL_DIV_FIRST && t.sel <= `CSEL_DIV_LAST) begin
      src   = SRC_DIV;
      shift = t.sel - `DIV_SHIFT_OFFSET;
    end else if (t.sel == `CSEL_DIV4096) begin
      src   = SRC_DIV;
      shift = `DIV4096_SHIFT;
    end
    mask = PRESCALE_W'((1 << shift) - 1);
  end

  // prohibited codes never tick, so a bad setting just freezes the count
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_reg <= 1'b0;
    end else begin
      case (src)
        SRC_FALL: tick_reg <= t.ev_fall; // [R11] [R14]
        SRC_RISE: tick_reg <= t.ev_rise;
        SRC_DIV:  tick_reg <= ((t.prescale & mask) == mask);
        default:  tick_reg <= 1'b0;
      endcase
    end
  end
  assign t.tick = tick_reg;

  sequence div2_run_s;
    (t.sel == `CSEL_DIV_FIRST) && t.tick ##1 (t.sel == `CSEL_DIV_FIRST);
  endsequence
  div2_spacing_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R21]
    div2_run_s |-> !t.tick ##1 t.tick)
    else $error("divide by 2 tick spacing wrong");
  bad_code_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R11]
    (t.sel > `CSEL_RISE && t.sel < `CSEL_DIV_FIRST) |=> !t.tick)
    else $error("prohibited clock code produced a tick");
endmodule : timer_tick_sel

// >>> hw/dual_timer.sv
// dual 8-bit timer/event counter, joinable into one 16-bit counter
`timescale 1ns/1ns
`include "timer_defs.svh"
module dual_timer
  import timer_pkg::*;
#(
  parameter int PRESCALE_W = 12
) (
  input  wire logic        clk_sys_i,         // system clock, 20 MHz
  input  wire logic        resetn_i,          // async reset, active low
  input  wire logic [15:0] sfr_addr_i,        // register address
  input  wire logic        sfr_wr_i,          // write strobe
  input  wire logic        sfr_rd_i,          // read strobe
  input  wire logic        sfr_word_i,        // 1 word access, 0 byte access
  input  wire logic [15:0] sfr_wdata_i,       // write data, byte in low lane
  output logic      [15:0] sfr_rdata_o,       // read data, one cycle later
  input  wire logic        event_input_ch1_i, // external count pin, channel 1
  input  wire logic        event_input_ch2_i, // external count pin, channel 2
  output logic             wave_output_ch1_o, // square wave, channel 1
  output logic             wave_output_ch2_o, // square wave, channel 2
  output logic             match_irq_ch1_o,   // match pulse, channel 1
  output logic             match_irq_ch2_o    // match pulse, channel 2
);
  logic [1:0]            rst_sync_reg;
  logic                  rstn;
  logic [7:0]            clock_select_reg;
  logic [7:0]            mode_control_reg;
  logic [7:0]            output_ctrl_reg;
  count_t                count_reg [2];
  count_t                compare_reg [2];
  logic [PRESCALE_W-1:0] prescale_reg;
  logic [2:0]            pin_sync_reg [2];
  logic [1:0]            pin_level_reg;
  logic [1:0]            ev_rise_reg;
  logic [1:0]            ev_fall_reg;
  logic [1:0]            tick;
  logic [1:0]            en_eff;
  logic [1:0]            step;
  logic [1:0]            clr;
  logic [1:0]            fire;
  logic [1:0]            out_en;
  logic [1:0]            wave_reg;
  logic [1:0]            irq_reg;
  logic [15:0]           rdata_reg;
  logic                  joined;
  logic                  match_joined;
  logic [15:0]           count16;
  logic [15:0]           compare16;
  logic                  byte_wr;
  logic [1:0]            event_pin;

  initial begin
    if (PRESCALE_W < `PRESCALE_BITS) $error("prescaler too narrow for divide by 4096");
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rstn = rst_sync_reg[1];

  // register writes; word writes are ignored so a wide store cannot tear
  assign byte_wr = sfr_wr_i && !sfr_word_i;

  always_ff @(posedge clk_sys_i or negedge rstn) begin
    if (!rstn) begin
      clock_select_reg <= `RST_CLOCK_SELECT; // [R12]
      mode_control_reg <= `RST_MODE_CONTROL;
      output_ctrl_reg  <= `RST_OUTPUT_CTRL;
    end else if (byte_wr) begin
      if (sfr_addr_i == `ADDR_CLOCK_SELECT) clock_select_reg <= sfr_wdata_i[7:0]; // [R12]
      if (sfr_addr_i == `ADDR_MODE_CONTROL) mode_control_reg <= sfr_wdata_i[7:0];
      if (sfr_addr_i == `ADDR_OUTPUT_CTRL)  output_ctrl_reg  <= sfr_wdata_i[7:0];
    end
  end

  // compare storage has no reset on purpose: contents are undefined until written
  always_ff @(posedge clk_sys_i) begin
    if (rstn && byte_wr) begin // [R3] [R5]
      if (sfr_addr_i == `ADDR_COMPARE_CH1) compare_reg[0] <= sfr_wdata_i[7:0]; // [R4]
      if (sfr_addr_i == `ADDR_COMPARE_CH2) compare_reg[1] <= sfr_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn) begin
    if (!rstn) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= prescale_reg + 1'b1;
    end
  end

  assign joined       = mode_control_reg[`BIT_JOINED]; // [R1]
  assign count16      = {count_reg[1], count_reg[0]}; // [R22]
  assign compare16    = {compare_reg[1], compare_reg[0]};
  assign match_joined = joined && mode_control_reg[`BIT_ENABLE_CH1] && tick[0]
                        && (count16 == compare16); // [R4]
  assign out_en       = {output_ctrl_reg[`BIT_OUT_EN_CH2], output_ctrl_reg[`BIT_OUT_EN_CH1]};
  assign event_pin    = {event_input_ch2_i, event_input_ch1_i};

  for (genvar i = 0; i < 2; i++) begin : g_ch // [R16]
    tick_if #(.PRESCALE_W(PRESCALE_W)) tk ();

    // a pin edge counts once the second and third stages agree
    always_ff @(posedge clk_sys_i or negedge rstn) begin
      if (!rstn) begin
        pin_sync_reg[i]  <= 3'h0;
        pin_level_reg[i] <= 1'b0;
        ev_rise_reg[i]   <= 1'b0;
        ev_fall_reg[i]   <= 1'b0;
      end else begin
        pin_sync_reg[i] <= {pin_sync_reg[i][1:0], event_pin[i]};
        if (pin_sync_reg[i][1] == pin_sync_reg[i][2]) begin
          pin_level_reg[i] <= pin_sync_reg[i][2];
        end
        ev_rise_reg[i] <= (pin_sync_reg[i][1] == pin_sync_reg[i][2])
                          && pin_sync_reg[i][2] && !pin_level_reg[i]; // [R14]
        ev_fall_reg[i] <= (pin_sync_reg[i][1] == pin_sync_reg[i][2])
                          && !pin_sync_reg[i][2] && pin_level_reg[i];
      end
    end

    assign tk.sel      = clock_select_reg[i*4 +: `CSEL_W]; // [R17]
    assign tk.ev_rise  = ev_rise_reg[i];
    assign tk.ev_fall  = ev_fall_reg[i];
    assign tk.prescale = prescale_reg;
    assign tick[i]     = tk.tick;

    timer_tick_sel #(.PRESCALE_W(PRESCALE_W)) u_sel (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn),
      .t         (tk)
    );

    // joined: channel 2 steps on channel 1 overflow, both run on channel 1 enable
    assign en_eff[i] = joined ? mode_control_reg[`BIT_ENABLE_CH1]
                              : mode_control_reg[i]; // [R20]
    if (i == 0) begin : g_lo
      assign step[i] = tick[0];
    end else begin : g_hi
      assign step[i] = joined ? (tick[0] && count_reg[0] == `COUNT_MAX) : tick[1]; // [R20]
    end
    assign clr[i]  = joined ? match_joined
                            : (en_eff[i] && tick[i] && count_reg[i] == compare_reg[i]);
    assign fire[i] = joined ? (i == 1 && match_joined) : clr[i]; // [R2]

    always_ff @(posedge clk_sys_i or negedge rstn) begin
      if (!rstn) begin
        count_reg[i] <= `RST_COUNT; // [R9]
      end else if (!en_eff[i]) begin
        count_reg[i] <= `RST_COUNT;
      end else if (clr[i]) begin
        count_reg[i] <= `RST_COUNT; // [R18]
      end else if (step[i]) begin
        count_reg[i] <= count_reg[i] + 1'b1; // [R7]
      end
    end

    always_ff @(posedge clk_sys_i or negedge rstn) begin
      if (!rstn) begin
        irq_reg[i] <= 1'b0;
      end else begin
        irq_reg[i] <= fire[i]; // [R2]
      end
    end

    always_ff @(posedge clk_sys_i or negedge rstn) begin
      if (!rstn) begin
        wave_reg[i] <= 1'b0;
      end else if (!out_en[i]) begin
        wave_reg[i] <= 1'b0;
      end else if (fire[i]) begin
        wave_reg[i] <= !wave_reg[i]; // [R15] [R19]
      end
    end
  end

  // word read of the low count address returns both halves from one edge
  always_ff @(posedge clk_sys_i or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 16'h0000;
    end else if (sfr_rd_i) begin
      rdata_reg <= 16'h0000;
      if (sfr_word_i) begin
        if (sfr_addr_i == `ADDR_COUNT_CH1) rdata_reg <= count16; // [R10]
      end else begin
        case (sfr_addr_i)
          `ADDR_CLOCK_SELECT: rdata_reg <= {8'h00, clock_select_reg};
          `ADDR_MODE_CONTROL: rdata_reg <= {8'h00, mode_control_reg};
          `ADDR_OUTPUT_CTRL:  rdata_reg <= {8'h00, output_ctrl_reg};
          `ADDR_COUNT_CH1:    rdata_reg <= {8'h00, count_reg[0]};
          `ADDR_COUNT_CH2:    rdata_reg <= {8'h00, count_reg[1]};
          `ADDR_COMPARE_CH1:  rdata_reg <= {8'h00, compare_reg[0]};
          `ADDR_COMPARE_CH2:  rdata_reg <= {8'h00, compare_reg[1]};
          default:            rdata_reg <= 16'h0000;
        endcase
      end
    end
  end

  assign sfr_rdata_o       = rdata_reg;
  assign wave_output_ch1_o = wave_reg[0];
  assign wave_output_ch2_o = wave_reg[1];
  assign match_irq_ch1_o   = irq_reg[0];
  assign match_irq_ch2_o   = irq_reg[1];

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn);

  sequence sep_hit_s;
    !joined && mode_control_reg[0] && tick[0] && count_reg[0] == compare_reg[0];
  endsequence
  match_irq_a: assert property (sep_hit_s |=> match_irq_ch1_o && count_reg[0] == 8'h00) // [R2]
    else $error("separate match did not raise irq and clear");
  match_once_a: assert property (match_irq_ch1_o |-> $past(!joined && en_eff[0] && tick[0]
    && count_reg[0] == compare_reg[0])) // [R18]
    else $error("irq without a match");
  count_step_a: assert property (!joined && mode_control_reg[0] && tick[0]
    && count_reg[0] != compare_reg[0] |=> count_reg[0] == $past(count_reg[0]) + 8'h01) // [R7]
    else $error("count did not step by one");
  wave_flip_a: assert property (out_en[0] && fire[0] ##1 out_en[0]
    |-> wave_output_ch1_o != $past(wave_output_ch1_o)) // [R19]
    else $error("wave did not invert on match");
  wave_quiet_a: assert property (!out_en[1] |=> !wave_output_ch2_o) // [R15]
    else $error("disabled wave output not low");
  joined_carry_a: assert property (joined && mode_control_reg[0] && tick[0]
    && count_reg[0] == 8'hFF && !match_joined
    |=> count_reg[1] == $past(count_reg[1]) + 8'h01 && count_reg[0] == 8'h00) // [R20]
    else $error("joined carry into upper byte lost");
  joined_irq_a: assert property (match_joined
    |=> match_irq_ch2_o && !match_irq_ch1_o && count16 == 16'h0000) // [R22]
    else $error("joined match handled wrong");
  stop_clear_a: assert property (!en_eff[1] |=> count_reg[1] == 8'h00) // [R1]
    else $error("stopped channel kept its count");
  word_read_a: assert property (sfr_rd_i && sfr_word_i && sfr_addr_i == `ADDR_COUNT_CH1
    |=> sfr_rdata_o == {$past(count_reg[1]), $past(count_reg[0])}) // [R10]
    else $error("word count read torn");
  reset_count_a: assert property (disable iff (1'b0) !rstn |=> count16 == 16'h0000 // [R9]
    && clock_select_reg == 8'h00)
    else $error("reset did not clear counts");
endmodule : dual_timer

// >>> tb/pin_stub.sv
// pin-side model: pulse source on the count pins, edge counter on the wave pins
`timescale 1ns/1ns
module pin_stub (
  input  wire logic clk_sys_i,         // system clock
  input  wire logic wave_output_ch1_i, // square wave, channel 1
  input  wire logic wave_output_ch2_i, // square wave, channel 2
  output logic      event_input_ch1_o, // count pin, channel 1
  output logic      event_input_ch2_o, // count pin, channel 2
  output int        tog1_o,            // wave edges seen, channel 1
  output int        tog2_o             // wave edges seen, channel 2
);
  logic w1_reg;
  logic w2_reg;

  initial begin
    event_input_ch1_o = 1'b0;
    event_input_ch2_o = 1'b0;
    tog1_o = 0;
    tog2_o = 0;
    w1_reg = 1'b0;
    w2_reg = 1'b0;
  end

  // levels held four clocks, well past the two-clock stability need
  task automatic pulse(input logic [1:0] mask, input int n);
    repeat (n) begin
      @(negedge clk_sys_i);
      event_input_ch1_o = mask[0];
      event_input_ch2_o = mask[1];
      repeat (4) @(negedge clk_sys_i);
      event_input_ch1_o = 1'b0;
      event_input_ch2_o = 1'b0;
      repeat (3) @(negedge clk_sys_i);
    end
  endtask : pulse

  always @(posedge clk_sys_i) begin
    w1_reg <= wave_output_ch1_i;
    w2_reg <= wave_output_ch2_i;
    if (wave_output_ch1_i !== w1_reg) tog1_o <= tog1_o + 1;
    if (wave_output_ch2_i !== w2_reg) tog2_o <= tog2_o + 1;
  end
endmodule : pin_stub

// >>> tb/testbench.sv
// self-checking bench for the dual timer
`timescale 1ns/1ns
`include "timer_defs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
  import timer_pkg::*;
  typedef struct {clk_code_t code; int period;} div_row_t;
  logic        clk_sys_i, resetn_i, wr, rd, word, ev1, ev2, w1, w2, irq1, irq2;
  logic [15:0] addr, wdata, rdata, got;
  int          err_count, num_checks, irq_cnt1, irq_cnt2, n, t0, i0, i1;
  div_row_t    rows [11] = '{'{4'h5, 2}, '{4'h6, 4}, '{4'h7, 8}, '{4'h8, 16},
    '{4'h9, 32}, '{4'hA, 64}, '{4'hB, 128}, '{4'hC, 256}, '{4'hD, 512},
    '{4'hE, 1024}, '{4'hF, 4096}};

  dual_timer dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_word_i(word), .sfr_wdata_i(wdata),
    .sfr_rdata_o(rdata), .event_input_ch1_i(ev1), .event_input_ch2_i(ev2),
    .wave_output_ch1_o(w1), .wave_output_ch2_o(w2), .match_irq_ch1_o(irq1),
    .match_irq_ch2_o(irq2));
  pin_stub pins (.clk_sys_i(clk_sys_i), .wave_output_ch1_i(w1), .wave_output_ch2_i(w2),
    .event_input_ch1_o(ev1), .event_input_ch2_o(ev2), .tog1_o(), .tog2_o());

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    if (irq1 === 1'b1) irq_cnt1 <= irq_cnt1 + 1;
    if (irq2 === 1'b1) irq_cnt2 <= irq_cnt2 + 1;
  end

  task automatic bus_wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(negedge clk_sys_i);
    addr = a;
    wdata = d;
    word = w;
    wr = 1'b1;
    @(negedge clk_sys_i);
    wr = 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] a, input logic w, output logic [15:0] d);
    @(negedge clk_sys_i);
    addr = a;
    word = w;
    rd = 1'b1;
    @(negedge clk_sys_i);
    rd = 1'b0;
    d = w ? rdata : {8'h00, rdata[7:0]};
  endtask : bus_rd

  // stop first, so a clock change never lands on a running count
  task automatic cfg(input logic [7:0] csel, input logic [7:0] mode, input logic [7:0] oc);
    bus_wr(`ADDR_MODE_CONTROL, 16'h0000, 1'b0);
    bus_wr(`ADDR_CLOCK_SELECT, {8'h00, csel}, 1'b0);
    bus_wr(`ADDR_OUTPUT_CTRL, {8'h00, oc}, 1'b0);
    bus_wr(`ADDR_MODE_CONTROL, {8'h00, mode}, 1'b0);
  endtask : cfg

  task automatic wait_irq(input logic ch, input int limit, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk_sys_i);
      cnt++;
    end while ((ch ? irq2 : irq1) !== 1'b1 && cnt < limit);
  endtask : wait_irq

  task automatic close_out;
    $display("checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  initial begin
    #3000000;
    err_count++;
    close_out;
  end

  task automatic do_reset;
    resetn_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    `CHK({w1, w2, irq1, irq2}, 4'h0)
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    bus_rd(`ADDR_COUNT_CH1, 1'b1, got);
    `CHK(got, 16'h0000)
    bus_rd(`ADDR_CLOCK_SELECT, 1'b0, got);
    `CHK(got, 16'h0000)
  endtask : do_reset

  initial begin
    {wr, rd, word, addr, wdata, irq_cnt1, irq_cnt2, err_count, num_checks} = '0;
    do_reset();
    bus_wr(`ADDR_COMPARE_CH1, 16'h005A, 1'b0);
    bus_wr(`ADDR_COMPARE_CH2, 16'h00A5, 1'b0);
    bus_wr(`ADDR_COMPARE_CH1, 16'h1234, 1'b1);
    bus_wr(`ADDR_COUNT_CH1, 16'h0077, 1'b0);
    bus_rd(`ADDR_COMPARE_CH1, 1'b0, got);
    `CHK(got, 16'h005A)
    bus_rd(`ADDR_COMPARE_CH2, 1'b0, got);
    `CHK(got, 16'h00A5)
    bus_rd(`ADDR_COUNT_CH1, 1'b0, got);
    `CHK(got, 16'h0000)
    bus_rd(16'hFF40, 1'b1, got);
    `CHK(got, 16'h0000)
    bus_wr(`ADDR_COMPARE_CH1, 16'h0000, 1'b0);
    t0 = pins.tog1_o;
    i0 = irq_cnt1;
    foreach (rows[k]) begin
      cfg({4'h0, rows[k].code}, 8'h01, 8'h01);
      wait_irq(1'b0, 5000, n);
      wait_irq(1'b0, 5000, n);
      `CHK(n, rows[k].period)
    end
    cfg(8'h00, 8'h00, 8'h01);
    `CHK(pins.tog1_o - t0, irq_cnt1 - i0)
    i0 = irq_cnt1;
    cfg(8'h02, 8'h01, 8'h00);
    repeat (200) @(negedge clk_sys_i);
    bus_rd(`ADDR_COUNT_CH1, 1'b0, got);
    `CHK({got, irq_cnt1 - i0}, {16'h0000, 32'd0})
    // lowered compare below the running count: full wrap before the next match
    bus_wr(`ADDR_COMPARE_CH1, 16'h0040, 1'b0);
    cfg(8'h05, 8'h01, 8'h00);
    repeat (60) @(negedge clk_sys_i);
    bus_wr(`ADDR_COMPARE_CH1, 16'h0005, 1'b0);
    wait_irq(1'b0, 1000, n);
    `CHK(n inside {[420:500]}, 1'b1)
    wait_irq(1'b0, 1000, n);
    `CHK(n, 12)
    // lowered compare followed by a restart: no wrap, plain interval again
    bus_wr(`ADDR_COMPARE_CH1, 16'h0003, 1'b0);
    cfg(8'h05, 8'h01, 8'h00);
    wait_irq(1'b0, 1000, n);
    wait_irq(1'b0, 1000, n);
    `CHK(n, 8)
    bus_wr(`ADDR_COMPARE_CH1, 16'h0001, 1'b0);
    bus_wr(`ADDR_COMPARE_CH2, 16'h0002, 1'b0);
    cfg(8'h10, 8'h03, 8'h00);
    i0 = irq_cnt1;
    i1 = irq_cnt2;
    pins.pulse(2'b11, 7);
    repeat (10) @(negedge clk_sys_i);
    `CHK(irq_cnt1 - i0, 3)
    `CHK(irq_cnt2 - i1, 2)
    bus_rd(`ADDR_COUNT_CH1, 1'b1, got);
    `CHK(got, 16'h0101)
    bus_wr(`ADDR_MODE_CONTROL, 16'h0000, 1'b0);
    bus_wr(`ADDR_COMPARE_CH1, 16'h0002, 1'b0);
    bus_wr(`ADDR_COMPARE_CH2, 16'h0001, 1'b0);
    t0 = pins.tog2_o;
    i1 = irq_cnt2;
    cfg(8'h05, 8'h05, 8'h10);
    wait_irq(1'b1, 1000, n);
    wait_irq(1'b1, 1000, n);
    `CHK(n, 518)
    `CHK(pins.tog2_o - t0, irq_cnt2 - i1)
    do_reset();
    close_out;
  end
endmodule : testbench
